/* rtl/lmt_threshold_regs.sv */
`timescale 1ns/100ps
module lmt_threshold_regs
  import lmt_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire lmt_cmd_type               host_cmd,
  output logic [7:0]                     host_rd_data,
  output logic                           host_rd_valid,
  input  wire logic signed [METER_W-1:0] meter_result,
  input  wire logic                      meter_valid,
  output lmt_ctrl_type                   meter_ctrl,
  output logic signed [METER_W-1:0]      meter_level,
  output logic                           over_threshold_flag,
  output logic [7:0]                     debounce_filter_config
);

  logic [1:0]               rst_sync_q;
  logic                     rstn_s;

  lmt_ctrl_type             ctrl_q;
  lmt_ctrl_type             ctrl_d;
  logic [7:0]               deb_q;
  logic [7:0]               deb_d;
  logic                     flag_q;
  logic                     flag_d;
  logic signed [METER_W-1:0] level_q;
  logic signed [METER_W-1:0] level_d;
  logic [7:0]               rd_data_q;
  logic [7:0]               rd_data_d;
  logic                     rd_valid_q;
  logic                     rd_valid_d;

  logic                     cmp_over;
  logic signed [METER_W-1:0] cmp_level;
  logic                     hit_thresh;
  logic                     hit_deb;
  logic                     is_write;

  // assembles the threshold register image as software sees it
  function automatic logic [7:0] thresh_image(lmt_ctrl_type c, logic f);
    logic [7:0] img;
    img                         = 8'h00;
    img[FLD_FLAG]               = f;
    img[FLD_GAIN]               = c.gain_boost;
    img[FLD_RECT]               = c.rect_on;
    img[FLD_TH_LSB +: TH_W]     = c.th_sel;
    return img;
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rstn_s = rst_sync_q[1];

  // comparator and gain shaping live beside the registers
  lmt_meter_cmp u_cmp (
    .sample (meter_result),
    .ctrl   (ctrl_q),
    .level  (cmp_level),
    .over   (cmp_over)
  );

  // command decode: low seven bits pick the register, bit 7 the direction
  assign hit_thresh = host_cmd.valid
                    && host_cmd.cmd[6:0] == CMD_THRESH;
  assign hit_deb    = host_cmd.valid
                    && host_cmd.cmd[6:0] == CMD_DEBOUNCE;
  assign is_write   = host_cmd.cmd[CMD_RW_BIT] == CMD_RW_WRITE;

  // next-state for register bank, flag and read port
  always_comb
  begin
    ctrl_d     = ctrl_q;
    deb_d      = deb_q;
    flag_d     = flag_q;
    level_d    = level_q;
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    // flag only follows fresh samples, so it holds between them
    if (meter_valid)
    begin
      flag_d  = cmp_over;
      level_d = cmp_level;
    end
    if (hit_thresh && is_write)
    begin
      // flag and reserved bits of the write data are dropped
      ctrl_d.gain_boost = host_cmd.data[FLD_GAIN];
      ctrl_d.rect_on    = host_cmd.data[FLD_RECT];
      ctrl_d.th_sel     = host_cmd.data[FLD_TH_LSB +: TH_W];
    end
    else if (hit_thresh)
    begin
      rd_data_d  = thresh_image(ctrl_q, flag_q);
      rd_valid_d = 1'b1;
    end
    if (hit_deb && is_write)
    begin
      deb_d = host_cmd.data;
    end
    else if (hit_deb)
    begin
      rd_data_d  = deb_q;
      rd_valid_d = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      ctrl_q     <= CTRL_RST;
      deb_q      <= DEBOUNCE_RST;
      flag_q     <= 1'b0;
      level_q    <= '0;
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      deb_q      <= deb_d;
      flag_q     <= flag_d;
      level_q    <= level_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign meter_ctrl             = ctrl_q;
  assign meter_level            = level_q;
  assign over_threshold_flag    = flag_q;
  assign debounce_filter_config = deb_q;
  assign host_rd_data           = rd_data_q;
  assign host_rd_valid          = rd_valid_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn_s);

  chk_flag_rises: assert property (
    meter_valid && cmp_over |=> over_threshold_flag
  ) else $error("flag not set after sample above threshold");

  chk_flag_clears: assert property (
    meter_valid && !cmp_over |=> !over_threshold_flag
  ) else $error("flag not cleared after sample below threshold");

  chk_flag_holds: assert property (
    !meter_valid |=> $stable(over_threshold_flag)
  ) else $error("flag moved without a meter sample");

  chk_thresh_write: assert property (
    hit_thresh && is_write
    |=> meter_ctrl.th_sel == $past(host_cmd.data[2:0])
  ) else $error("threshold select not taken from write");

  chk_gain_write: assert property (
    hit_thresh && is_write
    |=> meter_ctrl.gain_boost == $past(host_cmd.data[6])
  ) else $error("gain boost not taken from write");

  chk_rect_off: assert property (
    !meter_ctrl.rect_on && meter_valid && meter_result < 0
    && !meter_ctrl.gain_boost |=> meter_level < 0
  ) else $error("rectifier acted while disabled");

  chk_thresh_read: assert property (
    hit_thresh && !is_write |=> host_rd_valid
    && host_rd_data[6:5] == {meter_ctrl.gain_boost, meter_ctrl.rect_on}
    && host_rd_data[4:3] == 2'b00
  ) else $error("threshold read answered wrongly");

  chk_debounce_rw: assert property (
    hit_deb && is_write ##1 hit_deb && !is_write
    |=> host_rd_valid && host_rd_data == $past(host_cmd.data, 2)
  ) else $error("debounce register did not read back");

  chk_no_stray_read: assert property (
    !(host_cmd.valid && !is_write && (hit_thresh || hit_deb))
    |=> !host_rd_valid
  ) else $error("read answer without a read command");

  chk_flag_readback: assert property (
    hit_thresh && !is_write
    |=> host_rd_data[FLD_FLAG] == $past(over_threshold_flag)
  ) else $error("flag bit of threshold read is wrong");

  chk_th_readback: assert property (
    hit_thresh && !is_write
    |=> host_rd_data[FLD_TH_LSB +: TH_W] == meter_ctrl.th_sel
  ) else $error("threshold select of read is wrong");

  chk_rect_write: assert property (
    hit_thresh && is_write
    |=> meter_ctrl.rect_on == $past(host_cmd.data[FLD_RECT])
  ) else $error("rectifier enable not taken from write");

  chk_ctrl_holds: assert property (
    !(hit_thresh && is_write) |=> $stable(meter_ctrl)
  ) else $error("threshold register moved without a write");

  chk_deb_holds: assert property (
    !(hit_deb && is_write) |=> $stable(debounce_filter_config)
  ) else $error("debounce register moved without a write");

  chk_answer_holds: assert property (
    !host_rd_valid |-> $stable(host_rd_data)
  ) else $error("read data moved without an answer");

endmodule

/* rtl/lmt_pkg.sv */
package lmt_pkg;

  // command byte layout
  localparam int        CMD_RW_BIT      = 7;
  localparam logic [6:0] CMD_THRESH     = 7'h09;
  localparam logic [6:0] CMD_DEBOUNCE   = 7'h0a;
  localparam logic      CMD_RW_WRITE    = 1'b1;

  // threshold register fields
  localparam int        FLD_FLAG        = 7;
  localparam int        FLD_GAIN        = 6;
  localparam int        FLD_RECT        = 5;
  localparam int        FLD_TH_LSB      = 0;
  localparam int        TH_W            = 3;

  // values after reset
  localparam logic [7:0] THRESH_RST     = 8'h00;
  localparam logic [7:0] DEBOUNCE_RST   = 8'h00;

  // meter datapath
  localparam int        METER_W         = 16;
  localparam int        GAIN_SHIFT      = 4;
  localparam int        TH_STEP_SHIFT   = 12;

  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] data;
  } lmt_cmd_type;

  typedef struct packed {
    logic            gain_boost;
    logic            rect_on;
    logic [TH_W-1:0] th_sel;
  } lmt_ctrl_type;

  localparam lmt_ctrl_type CTRL_RST = '{
    gain_boost : THRESH_RST[FLD_GAIN],
    rect_on    : THRESH_RST[FLD_RECT],
    th_sel     : THRESH_RST[FLD_TH_LSB +: TH_W]
  };

endpackage

/* rtl/lmt_meter_cmp.sv */
`timescale 1ns/100ps
module lmt_meter_cmp
  import lmt_pkg::*;
(
  input  wire logic signed [METER_W-1:0] sample,
  input  wire lmt_ctrl_type              ctrl,
  output logic signed [METER_W-1:0]      level,
  output logic                           over
);

  localparam int EXT_W = METER_W + GAIN_SHIFT + 1;
  localparam logic signed [EXT_W-1:0] SAT_HI = EXT_W'((1 << (METER_W-1)) - 1);
  localparam logic signed [EXT_W-1:0] SAT_LO = -EXT_W'(1 << (METER_W-1));

  logic signed [EXT_W-1:0] ext;
  logic signed [EXT_W-1:0] shaped;
  logic signed [EXT_W-1:0] boosted;
  logic        [EXT_W-1:0] mag;
  logic        [EXT_W-1:0] thresh;

  // magnitude kept GAIN_SHIFT plus one bits wider so boost and full negative scale do not wrap
  always_comb
  begin
    ext     = EXT_W'(sample);
    shaped  = (ctrl.rect_on && ext < 0) ? -ext : ext;
    boosted = ctrl.gain_boost ? (shaped <<< GAIN_SHIFT) : shaped;
    mag     = (ext < 0) ? EXT_W'(-ext) : EXT_W'(ext);
    if (ctrl.gain_boost)
    begin
      mag = mag << GAIN_SHIFT;
    end
    // steps of one eighth of full scale
    thresh = EXT_W'(ctrl.th_sel) << TH_STEP_SHIFT;
    over   = mag > thresh;
    // level output saturates rather than wrapping under boost
    if (boosted > SAT_HI)
    begin
      level = SAT_HI[METER_W-1:0];
    end
    else if (boosted < SAT_LO)
    begin
      level = SAT_LO[METER_W-1:0];
    end
    else
    begin
      level = boosted[METER_W-1:0];
    end
  end

endmodule

/* testbench/lmt_host_model.sv */
`timescale 1ns/100ps
module lmt_host_model
  import lmt_pkg::*;
(
  input  wire logic        core_clk,
  output lmt_cmd_type      host_cmd,
  input  wire logic [7:0]  host_rd_data,
  input  wire logic        host_rd_valid
);
  // bus idle at time zero
  initial host_cmd = '0;

  // one command byte per call; answer taken one cycle after the strobe
  task automatic xfer(input logic [7:0] c, input logic [7:0] d,
                      output logic v, output logic [7:0] r);
    @(negedge core_clk);
    host_cmd <= '{valid: 1'b1, cmd: c, data: d};
    @(negedge core_clk);
    host_cmd.valid <= 1'b0;
    host_cmd.data  <= ~d; // stale data must not look valid
    v = host_rd_valid;
    r = host_rd_data;
  endtask

  // write then read on adjacent edges; answer taken after the read strobe
  task automatic wr_rd(input logic [7:0] c, input logic [7:0] d,
                       output logic v, output logic [7:0] r);
    @(negedge core_clk);
    host_cmd <= '{valid: 1'b1, cmd: c | 8'h80, data: d};
    @(negedge core_clk);
    host_cmd <= '{valid: 1'b1, cmd: c & 8'h7f, data: ~d};
    @(negedge core_clk);
    host_cmd.valid <= 1'b0;
    v = host_rd_valid;
    r = host_rd_data;
  endtask
endmodule

/* testbench/tb_lmt_threshold_regs.sv */
`timescale 1ns/100ps
module tb_lmt_threshold_regs;
  import lmt_pkg::*;
  logic                      core_clk;
  logic                      rstn;
  logic                      meter_valid;
  logic                      over;
  logic                      rv;
  logic                      vld;
  logic signed [METER_W-1:0] meter_result;
  logic signed [METER_W-1:0] level;
  logic [7:0]                rd_data;
  logic [7:0]                rd;
  logic [7:0]                dbc;
  lmt_cmd_type               host_cmd;
  lmt_ctrl_type              ctrl;
  int                        miscompares;
  int                        cmp_count;
  int                        cyc;

  lmt_threshold_regs i_lmt_threshold_regs (
    .core_clk              (core_clk),
    .rstn                  (rstn),
    .host_cmd              (host_cmd),
    .host_rd_data          (rd_data),
    .host_rd_valid         (rv),
    .meter_result          (meter_result),
    .meter_valid           (meter_valid),
    .meter_ctrl            (ctrl),
    .meter_level           (level),
    .over_threshold_flag   (over),
    .debounce_filter_config(dbc)
  );

  lmt_host_model i_lmt_host_model (
    .core_clk     (core_clk),
    .host_cmd     (host_cmd),
    .host_rd_data (rd_data),
    .host_rd_valid(rv)
  );

  // 40 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic results;
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read answer is the strobe plus the byte
  task automatic rdx(input logic [7:0] c, input logic [7:0] e);
    logic       v;
    logic [7:0] r;
    i_lmt_host_model.xfer(c, 8'h00, v, r);
    chk({7'h00, v, r}, {7'h00, 1'b1, e});
  endtask

  // back to back write and read, answer must carry the new byte
  task automatic wrd(input logic [7:0] c, input logic [7:0] d,
                     input logic [7:0] e);
    logic       v;
    logic [7:0] r;
    i_lmt_host_model.wr_rd(c, d, v, r);
    chk({7'h00, v, r}, {7'h00, 1'b1, e});
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic       v;
    logic [7:0] r;
    i_lmt_host_model.xfer(c, d, v, r);
  endtask

  // one meter sample, result settled at the next falling edge
  task automatic smp(input logic signed [15:0] s);
    @(negedge core_clk);
    meter_result = s;
    meter_valid  = 1'b1;
    @(negedge core_clk);
    meter_valid  = 1'b0;
    meter_result = ~s;
  endtask

  // hang guard, tests need well under a thousand cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    rstn         = 1'b0;
    meter_valid  = 1'b0;
    meter_result = '0;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    rdx(8'h09, 8'h00);
    rdx(8'h0a, 8'h00);
    wr(8'h89, 8'hff);
    chk(16'(ctrl), 16'h001f);
    rdx(8'h09, 8'h67);
    wr(8'h8a, 8'ha5);
    chk(16'(dbc), 16'h00a5);
    rdx(8'h0a, 8'ha5);
    i_lmt_host_model.xfer(8'h0b, 8'h00, vld, rd);
    chk(16'(vld), 16'h0000);
    wr(8'h8b, 8'h5a);
    chk(16'(dbc), 16'h00a5);
    wrd(8'h0a, 8'h3c, 8'h3c);
    wrd(8'h09, 8'h9a, 8'h02);
    // every threshold code, just above, mirrored and exactly at
    for (int t = 0; t < 8; t++)
    begin
      wr(8'h89, 8'(t));
      smp(16'(t * 4096 + 1));
      chk(16'(over), 16'h0001);
      rdx(8'h09, 8'(8'h80 | t));
      smp(16'(-(t * 4096 + 1)));
      chk(16'(over), 16'h0001);
      chk(level, 16'(-(t * 4096 + 1)));
      smp(16'(t * 4096));
      chk(16'(over), 16'h0000);
      rdx(8'h09, 8'(t));
    end
    wr(8'h89, 8'h41);
    smp(16'sd300);
    chk(16'(over), 16'h0001);
    chk(level, 16'd4800);
    smp(16'sd256);
    chk(16'(over), 16'h0000);
    smp(16'sd4000);
    chk(level, 16'h7fff);
    wr(8'h89, 8'h20);
    smp(-16'sd5000);
    chk(level, 16'd5000);
    wr(8'h89, 8'h00);
    smp(-16'sd5000);
    chk(level, 16'hec78);
    results();
  end
endmodule
